// file: design/aocd_pkg.sv
package aocd_pkg;

   typedef enum logic [3:0]
   {
      AOCD_OP_NONE = 4'b0000,
      AOCD_OP_SEG = 4'b0001,
      AOCD_OP_SUM = 4'b0010,
      AOCD_OP_SUMC = 4'b0011,
      AOCD_OP_DIFF = 4'b0100,
      AOCD_OP_BDIFF = 4'b0101,
      AOCD_OP_CMP = 4'b0110,
      AOCD_OP_NEG = 4'b0111,
      AOCD_OP_MUL = 4'b1000,
      AOCD_OP_INC = 4'b1001,
      AOCD_OP_DEC = 4'b1010,
      AOCD_OP_ASF = 4'b1011,
      AOCD_OP_ADF = 4'b1100,
      AOCD_OP_BSF = 4'b1101,
      AOCD_OP_BDF = 4'b1110,
      AOCD_OP_ILLEGAL = 4'b1111
   } aocd_op_t;

   typedef enum logic [1:0]
   {
      AOCD_KIND_SINGLE = 2'b00,
      AOCD_KIND_REGRM = 2'b01,
      AOCD_KIND_IMMRM = 2'b10,
      AOCD_KIND_ACC = 2'b11
   } aocd_kind_t;

   typedef enum logic [1:0]
   {
      AOCD_ST_OPCODE = 2'b00,
      AOCD_ST_MODRM = 2'b01,
      AOCD_ST_TAIL = 2'b10
   } aocd_state_t;

   localparam logic [7:0] PFX_CODE = 8'h2E;
   localparam logic [7:0] PFX_STACK = 8'h36;
   localparam logic [7:0] PFX_DATA = 8'h3E;
   localparam logic [7:0] PFX_EXTRA = 8'h26;
   localparam logic [5:0] OPC_SUM_RM = 6'h00;
   localparam logic [5:0] OPC_SUMC_RM = 6'h04;
   localparam logic [5:0] OPC_DIFF_RM = 6'h0A;
   localparam logic [5:0] OPC_BDIFF_RM = 6'h06;
   localparam logic [5:0] OPC_CMP_RM = 6'h0E;
   localparam logic [5:0] OPC_IMM_GRP = 6'h20;
   localparam logic [6:0] OPC_SUM_ACC = 7'h02;
   localparam logic [6:0] OPC_SUMC_ACC = 7'h0A;
   localparam logic [6:0] OPC_DIFF_ACC = 7'h16;
   localparam logic [6:0] OPC_BDIFF_ACC = 7'h0E;
   localparam logic [6:0] OPC_CMP_ACC = 7'h1E;
   localparam logic [6:0] OPC_UNARY_GRP = 7'h7B;
   localparam logic [6:0] OPC_STEP_GRP = 7'h7F;
   localparam logic [4:0] OPC_INC_SHORT = 5'h08;
   localparam logic [4:0] OPC_DEC_SHORT = 5'h09;
   localparam logic [7:0] OPC_ASCII_SUM = 8'h37;
   localparam logic [7:0] OPC_ASCII_DIFF = 8'h3F;
   localparam logic [7:0] OPC_BCD_SUM = 8'h27;
   localparam logic [7:0] OPC_BCD_DIFF = 8'h2F;

   localparam logic [2:0] SEL_SUM = 3'h0;
   localparam logic [2:0] SEL_SUMC = 3'h2;
   localparam logic [2:0] SEL_BDIFF = 3'h3;
   localparam logic [2:0] SEL_DIFF = 3'h5;
   localparam logic [2:0] SEL_CMP = 3'h7;
   localparam logic [2:0] SEL_NEG = 3'h3;
   localparam logic [2:0] SEL_MUL = 3'h4;
   localparam logic [2:0] SEL_INC = 3'h0;
   localparam logic [2:0] SEL_DEC = 3'h1;
   localparam logic [1:0] MOD_NODISP = 2'h0;
   localparam logic [1:0] MOD_DISP8 = 2'h1;
   localparam logic [1:0] MOD_DISP16 = 2'h2;
   localparam logic [1:0] MOD_REG = 2'h3;
   localparam logic [2:0] RM_DIRECT = 3'h6;

   localparam logic [7:0] CLK_PREFIX = 8'h02;
   localparam logic [7:0] CLK_RR_REG = 8'h03;
   localparam logic [7:0] CLK_RR_MEM = 8'h0A;
   localparam logic [7:0] CLK_IMM_REG = 8'h04;
   localparam logic [7:0] CLK_IMM_MEM = 8'h10;
   localparam logic [7:0] CLK_ACC_BYTE = 8'h03;
   localparam logic [7:0] CLK_ACC_WORD = 8'h04;
   localparam logic [7:0] CLK_STEP_REG = 8'h03;
   localparam logic [7:0] CLK_STEP_MEM = 8'h0F;
   localparam logic [7:0] CLK_SHORT = 8'h03;
   localparam logic [7:0] CLK_ASCII_SUM = 8'h08;
   localparam logic [7:0] CLK_ASCII_DIFF = 8'h07;
   localparam logic [7:0] CLK_BCD = 8'h04;
   localparam logic [7:0] CLK_MUL_RB_MIN = 8'h1A;
   localparam logic [7:0] CLK_MUL_RB_MAX = 8'h1C;
   localparam logic [7:0] CLK_MUL_RW_MIN = 8'h23;
   localparam logic [7:0] CLK_MUL_RW_MAX = 8'h25;
   localparam logic [7:0] CLK_MUL_MB_MIN = 8'h20;
   localparam logic [7:0] CLK_MUL_MB_MAX = 8'h22;
   localparam logic [7:0] CLK_MUL_MW_MIN = 8'h29;
   localparam logic [7:0] CLK_MUL_MW_MAX = 8'h2B;
   localparam logic [7:0] CLK_MUL_MW_MAX_NARROW = 8'h30;
   localparam logic [7:0] CLK_NARROW_WORD_EXTRA = 8'h04;

endpackage : aocd_pkg

// file: design/aocd_clk_table.sv
`timescale 1ns/10ps
module aocd_clk_table
   import aocd_pkg::*;
(
   input wire aocd_op_t i_op,
   input wire aocd_kind_t i_kind,
   input wire logic i_mem,
   input wire logic i_word,
   output logic [7:0] o_wide_min,
   output logic [7:0] o_wide_max,
   output logic [7:0] o_narrow_min,
   output logic [7:0] o_narrow_max
);

   logic is_mul;
   logic [7:0] rr_cnt;
   logic [7:0] imm_cnt;
   logic [7:0] acc_cnt;
   logic [7:0] step_cnt;
   logic [7:0] alu_cnt;
   logic [7:0] mul_min;
   logic [7:0] mul_max;
   logic [7:0] extra;

   assign is_mul = (i_op == AOCD_OP_MUL);
   assign rr_cnt = i_mem ? CLK_RR_MEM : CLK_RR_REG;
   assign imm_cnt = (i_op == AOCD_OP_CMP) ? rr_cnt
                  : (i_mem ? CLK_IMM_MEM : CLK_IMM_REG);
   assign acc_cnt = i_word ? CLK_ACC_WORD : CLK_ACC_BYTE;
   assign step_cnt = i_mem ? CLK_STEP_MEM : CLK_STEP_REG;
   assign alu_cnt = (i_kind == AOCD_KIND_IMMRM) ? imm_cnt
                  : (i_kind == AOCD_KIND_ACC) ? acc_cnt
                  : rr_cnt;
   assign mul_min = i_mem ? (i_word ? CLK_MUL_MW_MIN : CLK_MUL_MB_MIN)
                  : (i_word ? CLK_MUL_RW_MIN : CLK_MUL_RB_MIN);
   assign mul_max = i_mem ? (i_word ? CLK_MUL_MW_MAX : CLK_MUL_MB_MAX)
                  : (i_word ? CLK_MUL_RW_MAX : CLK_MUL_RB_MAX);

   always_comb
   begin
      case (i_op)
         AOCD_OP_SEG: o_wide_min = CLK_PREFIX;
         AOCD_OP_ASF: o_wide_min = CLK_ASCII_SUM;
         AOCD_OP_ADF: o_wide_min = CLK_ASCII_DIFF;
         AOCD_OP_BSF: o_wide_min = CLK_BCD;
         AOCD_OP_BDF: o_wide_min = CLK_BCD;
         AOCD_OP_INC: o_wide_min = (i_kind == AOCD_KIND_SINGLE) ? CLK_SHORT : step_cnt;
         AOCD_OP_DEC: o_wide_min = (i_kind == AOCD_KIND_SINGLE) ? CLK_SHORT : step_cnt;
         AOCD_OP_MUL: o_wide_min = mul_min;
         AOCD_OP_SUM: o_wide_min = alu_cnt;
         AOCD_OP_SUMC: o_wide_min = alu_cnt;
         AOCD_OP_DIFF: o_wide_min = alu_cnt;
         AOCD_OP_BDIFF: o_wide_min = alu_cnt;
         AOCD_OP_CMP: o_wide_min = alu_cnt;
         AOCD_OP_NEG: o_wide_min = rr_cnt;
         default: o_wide_min = 8'h00;
      endcase
   end

   assign o_wide_max = is_mul ? mul_max : o_wide_min;
   // Clock counts are quoted for the wide bus; on the narrow bus word memory traffic costs a second transfer
   assign extra = (i_mem && i_word && !is_mul
                  && (i_kind == AOCD_KIND_REGRM || i_kind == AOCD_KIND_IMMRM))
                  ? CLK_NARROW_WORD_EXTRA : 8'h00;
   assign o_narrow_min = o_wide_min + extra;
   assign o_narrow_max = (is_mul && i_mem && i_word) ? CLK_MUL_MW_MAX_NARROW
                       : o_wide_max + extra;

endmodule : aocd_clk_table

// file: design/aocd_decoder.sv
`timescale 1ns/10ps
module aocd_decoder
   import aocd_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_byte_valid,
   input wire logic [7:0] i_byte,
   output logic o_byte_ready,
   output logic o_op_valid,
   output aocd_op_t o_op,
   output aocd_kind_t o_kind,
   output logic [1:0] o_seg_field,
   output logic o_size_bit,
   output logic o_orient_bit,
   output logic o_widen_bit,
   output logic o_mem,
   output logic [1:0] o_addr_kind_field,
   output logic [2:0] o_operand_select_field,
   output logic [2:0] o_mem_operand_field,
   output logic [1:0] o_disp_count,
   output logic [1:0] o_imm_count,
   output logic [7:0] o_clk_wide_min,
   output logic [7:0] o_clk_wide_max,
   output logic [7:0] o_clk_narrow_min,
   output logic [7:0] o_clk_narrow_max
);

   aocd_state_t state_reg;
   aocd_state_t state_next;
   aocd_op_t op_reg;
   aocd_kind_t kind_reg;
   logic [7:0] opc_reg;
   logic [7:0] modrm_reg;
   logic [2:0] left_reg;
   logic [2:0] left_next;
   logic ready_reg;

   logic take;
   logic is_prefix;
   aocd_op_t dec_op;
   aocd_kind_t dec_kind;
   logic [1:0] acc_imm;
   logic [1:0] grp_imm;
   logic [1:0] disp_cnt;
   logic [1:0] imm_cnt;
   aocd_op_t grp_op;
   logic [2:0] sel;
   logic [7:0] fin_opc;
   logic [7:0] fin_modrm;
   aocd_op_t fin_op;
   aocd_kind_t fin_kind;
   logic fin_mem;
   logic done;
   logic [7:0] c_wide_min;
   logic [7:0] c_wide_max;
   logic [7:0] c_narrow_min;
   logic [7:0] c_narrow_max;

   assign take = i_byte_valid && ready_reg;
   assign is_prefix = (i_byte == PFX_CODE) || (i_byte == PFX_STACK)
                    || (i_byte == PFX_DATA) || (i_byte == PFX_EXTRA);

   // Prefix match goes first: 26/2E/36/3E sit inside the fix-up opcode neighbourhood
   assign dec_op = is_prefix ? AOCD_OP_SEG
      : (i_byte == OPC_ASCII_SUM) ? AOCD_OP_ASF
      : (i_byte == OPC_ASCII_DIFF) ? AOCD_OP_ADF
      : (i_byte == OPC_BCD_SUM) ? AOCD_OP_BSF
      : (i_byte == OPC_BCD_DIFF) ? AOCD_OP_BDF
      : (i_byte[7:2] == OPC_SUM_RM) ? AOCD_OP_SUM
      : (i_byte[7:2] == OPC_SUMC_RM) ? AOCD_OP_SUMC
      : (i_byte[7:2] == OPC_DIFF_RM) ? AOCD_OP_DIFF
      : (i_byte[7:2] == OPC_BDIFF_RM) ? AOCD_OP_BDIFF
      : (i_byte[7:2] == OPC_CMP_RM) ? AOCD_OP_CMP
      : (i_byte[7:1] == OPC_SUM_ACC) ? AOCD_OP_SUM
      : (i_byte[7:1] == OPC_SUMC_ACC) ? AOCD_OP_SUMC
      : (i_byte[7:1] == OPC_DIFF_ACC) ? AOCD_OP_DIFF
      : (i_byte[7:1] == OPC_BDIFF_ACC) ? AOCD_OP_BDIFF
      : (i_byte[7:1] == OPC_CMP_ACC) ? AOCD_OP_CMP
      : (i_byte[7:3] == OPC_INC_SHORT) ? AOCD_OP_INC
      : (i_byte[7:3] == OPC_DEC_SHORT) ? AOCD_OP_DEC
      : ((i_byte[7:2] == OPC_IMM_GRP) || (i_byte[7:1] == OPC_UNARY_GRP)
         || (i_byte[7:1] == OPC_STEP_GRP)) ? AOCD_OP_NONE
      : AOCD_OP_ILLEGAL;

   assign dec_kind = (i_byte[7:2] == OPC_IMM_GRP) ? AOCD_KIND_IMMRM
      : ((i_byte[7:1] == OPC_UNARY_GRP) || (i_byte[7:1] == OPC_STEP_GRP)
         || (i_byte[7:2] == OPC_SUM_RM) || (i_byte[7:2] == OPC_SUMC_RM)
         || (i_byte[7:2] == OPC_DIFF_RM) || (i_byte[7:2] == OPC_BDIFF_RM)
         || (i_byte[7:2] == OPC_CMP_RM)) ? AOCD_KIND_REGRM
      : ((i_byte[7:1] == OPC_SUM_ACC) || (i_byte[7:1] == OPC_SUMC_ACC)
         || (i_byte[7:1] == OPC_DIFF_ACC) || (i_byte[7:1] == OPC_BDIFF_ACC)
         || (i_byte[7:1] == OPC_CMP_ACC)) ? AOCD_KIND_ACC
      : AOCD_KIND_SINGLE;

   assign acc_imm = {1'b0, i_byte[0]} + 2'h1;
   // Sign-extended byte (s=1) never needs a high data byte
   assign grp_imm = (opc_reg[1:0] == 2'b01) ? 2'h2 : 2'h1;

   assign sel = i_byte[5:3];
   assign grp_op = (opc_reg[7:2] == OPC_IMM_GRP) ?
        ((sel == SEL_SUM) ? AOCD_OP_SUM
         : (sel == SEL_SUMC) ? AOCD_OP_SUMC
         : (sel == SEL_BDIFF) ? AOCD_OP_BDIFF
         : (sel == SEL_DIFF) ? AOCD_OP_DIFF
         : (sel == SEL_CMP) ? AOCD_OP_CMP : AOCD_OP_ILLEGAL)
      : (opc_reg[7:1] == OPC_UNARY_GRP) ?
        ((sel == SEL_NEG) ? AOCD_OP_NEG
         : (sel == SEL_MUL) ? AOCD_OP_MUL : AOCD_OP_ILLEGAL)
      : (opc_reg[7:1] == OPC_STEP_GRP) ?
        ((sel == SEL_INC) ? AOCD_OP_INC
         : (sel == SEL_DEC) ? AOCD_OP_DEC : AOCD_OP_ILLEGAL)
      : op_reg;

   assign disp_cnt = (i_byte[7:6] == MOD_DISP16) ? 2'h2
                   : (i_byte[7:6] == MOD_DISP8) ? 2'h1
                   : (i_byte[7:6] == MOD_NODISP && i_byte[2:0] == RM_DIRECT) ? 2'h2
                   : 2'h0;
   assign imm_cnt = (kind_reg == AOCD_KIND_IMMRM) ? grp_imm : 2'h0;

   assign fin_opc = (state_reg == AOCD_ST_OPCODE) ? i_byte : opc_reg;
   assign fin_modrm = (state_reg == AOCD_ST_MODRM) ? i_byte : modrm_reg;
   assign fin_op = (state_reg == AOCD_ST_OPCODE) ? dec_op
                 : (state_reg == AOCD_ST_MODRM) ? grp_op : op_reg;
   assign fin_kind = (state_reg == AOCD_ST_OPCODE) ? dec_kind : kind_reg;
   assign fin_mem = (fin_kind == AOCD_KIND_REGRM || fin_kind == AOCD_KIND_IMMRM)
                 && (fin_modrm[7:6] != MOD_REG);

   // Illegal group selections end at the operand byte; their length is not known here
   always_comb
   begin
      state_next = state_reg;
      left_next = left_reg;
      done = 1'b0;
      case (state_reg)
         AOCD_ST_OPCODE:
         begin
            if (take)
            begin
               if (dec_kind == AOCD_KIND_REGRM || dec_kind == AOCD_KIND_IMMRM)
                  state_next = AOCD_ST_MODRM;
               else if (dec_kind == AOCD_KIND_ACC)
               begin
                  state_next = AOCD_ST_TAIL;
                  left_next = {1'b0, acc_imm};
               end
               else
                  done = 1'b1;
            end
         end
         AOCD_ST_MODRM:
         begin
            if (take)
            begin
               left_next = {1'b0, disp_cnt} + {1'b0, imm_cnt};
               if (grp_op == AOCD_OP_ILLEGAL || left_next == 3'h0)
               begin
                  state_next = AOCD_ST_OPCODE;
                  done = 1'b1;
               end
               else
                  state_next = AOCD_ST_TAIL;
            end
         end
         AOCD_ST_TAIL:
         begin
            if (take)
            begin
               left_next = left_reg - 3'h1;
               if (left_reg == 3'h1)
               begin
                  state_next = AOCD_ST_OPCODE;
                  done = 1'b1;
               end
            end
         end
         default:
         begin
            state_next = AOCD_ST_OPCODE;
            left_next = 3'h0;
         end
      endcase
   end

   aocd_clk_table u_clk_table
   (
      .i_op(fin_op),
      .i_kind(fin_kind),
      .i_mem(fin_mem),
      .i_word(fin_opc[0]),
      .o_wide_min(c_wide_min),
      .o_wide_max(c_wide_max),
      .o_narrow_min(c_narrow_min),
      .o_narrow_max(c_narrow_max)
   );

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         state_reg <= AOCD_ST_OPCODE;
         ready_reg <= 1'b0;
         left_reg <= 3'h0;
         op_reg <= AOCD_OP_NONE;
         kind_reg <= AOCD_KIND_SINGLE;
         opc_reg <= 8'h00;
         modrm_reg <= 8'h00;
      end
      else
      begin
         state_reg <= state_next;
         ready_reg <= 1'b1;
         left_reg <= left_next;
         if (take && state_reg == AOCD_ST_OPCODE)
         begin
            opc_reg <= i_byte;
            op_reg <= dec_op;
            kind_reg <= dec_kind;
            modrm_reg <= 8'h00;
         end
         if (take && state_reg == AOCD_ST_MODRM)
         begin
            modrm_reg <= i_byte;
            op_reg <= grp_op;
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         o_op_valid <= 1'b0;
         o_op <= AOCD_OP_NONE;
         o_kind <= AOCD_KIND_SINGLE;
         o_seg_field <= 2'h0;
         o_size_bit <= 1'b0;
         o_orient_bit <= 1'b0;
         o_widen_bit <= 1'b0;
         o_mem <= 1'b0;
         o_addr_kind_field <= 2'h0;
         o_operand_select_field <= 3'h0;
         o_mem_operand_field <= 3'h0;
         o_disp_count <= 2'h0;
         o_imm_count <= 2'h0;
         o_clk_wide_min <= 8'h00;
         o_clk_wide_max <= 8'h00;
         o_clk_narrow_min <= 8'h00;
         o_clk_narrow_max <= 8'h00;
      end
      else
      begin
         o_op_valid <= done;
         if (done)
         begin
            o_op <= fin_op;
            o_kind <= fin_kind;
            o_seg_field <= (fin_op == AOCD_OP_SEG) ? fin_opc[4:3] : 2'h0;
            o_size_bit <= fin_opc[0];
            o_orient_bit <= fin_opc[1];
            o_widen_bit <= (fin_kind == AOCD_KIND_IMMRM) && fin_opc[1];
            o_mem <= fin_mem;
            o_addr_kind_field <= fin_modrm[7:6];
            o_operand_select_field <= fin_modrm[5:3];
            o_mem_operand_field <= fin_modrm[2:0];
            o_disp_count <= fin_mem ? disp_cnt_of(fin_modrm) : 2'h0;
            o_imm_count <= (fin_kind == AOCD_KIND_IMMRM) ? grp_imm
                         : (fin_kind == AOCD_KIND_ACC) ? opc_reg[0] + 2'h1 : 2'h0;
            o_clk_wide_min <= c_wide_min;
            o_clk_wide_max <= c_wide_max;
            o_clk_narrow_min <= c_narrow_min;
            o_clk_narrow_max <= c_narrow_max;
         end
      end
   end

   assign o_byte_ready = ready_reg;

   function automatic logic [1:0] disp_cnt_of(input logic [7:0] mrm);
      disp_cnt_of = (mrm[7:6] == MOD_DISP16) ? 2'h2
                  : (mrm[7:6] == MOD_DISP8) ? 2'h1
                  : (mrm[7:6] == MOD_NODISP && mrm[2:0] == RM_DIRECT) ? 2'h2 : 2'h0;
   endfunction : disp_cnt_of

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   sequence s_take_fix;
      take && state_reg == AOCD_ST_OPCODE && i_byte == OPC_ASCII_SUM;
   endsequence
   sequence s_out_fix;
      o_op_valid && o_op == AOCD_OP_ASF && o_clk_wide_min == 8'h08;
   endsequence

   chk_prefix_count: assert property (
      take && state_reg == AOCD_ST_OPCODE && i_byte == PFX_DATA
      |=> o_op_valid && o_op == AOCD_OP_SEG && o_seg_field == 2'h3
          && o_clk_wide_min == 8'h02 && o_clk_narrow_min == 8'h02)
      else $error("prefix decode or count wrong");
   chk_rr_counts: assert property (
      o_op_valid && o_kind == AOCD_KIND_REGRM && o_op == AOCD_OP_SUM
      |-> o_clk_wide_min == (o_mem ? 8'h0A : 8'h03))
      else $error("register form count wrong");
   chk_imm_bytes: assert property (
      o_op_valid && o_kind == AOCD_KIND_IMMRM
      |-> o_imm_count == ((!o_widen_bit && o_size_bit) ? 2'h2 : 2'h1))
      else $error("immediate byte count wrong");
   chk_imm_clocks: assert property (
      o_op_valid && o_kind == AOCD_KIND_IMMRM && o_op != AOCD_OP_CMP
      |-> o_clk_wide_min == (o_mem ? 8'h10 : 8'h04))
      else $error("immediate form count wrong");
   chk_acc_path: assert property (
      take && state_reg == AOCD_ST_OPCODE && i_byte == 8'h05
      ##1 take [*2] |=> o_op_valid && o_op == AOCD_OP_SUM && o_clk_wide_min == 8'h04)
      else $error("accumulator word form wrong");
   chk_fix_timing: assert property (s_take_fix |=> s_out_fix)
      else $error("ascii sum fix wrong");
   chk_bcd_counts: assert property (
      o_op_valid && (o_op == AOCD_OP_BSF || o_op == AOCD_OP_BDF)
      |-> o_clk_wide_min == 8'h04 && o_clk_narrow_min == 8'h04)
      else $error("decimal fix count wrong");
   chk_mul_range: assert property (
      o_op_valid && o_op == AOCD_OP_MUL && o_mem && o_size_bit
      |-> o_clk_wide_max == 8'h2B && o_clk_narrow_max == 8'h30)
      else $error("product count wrong");
   chk_narrow_extra: assert property (
      o_op_valid && o_mem && o_size_bit && o_op != AOCD_OP_MUL
      |-> o_clk_narrow_min == o_clk_wide_min + 8'h04)
      else $error("narrow word extra wrong");
   chk_step_counts: assert property (
      o_op_valid && (o_op == AOCD_OP_INC || o_op == AOCD_OP_DEC)
      |-> o_clk_wide_min == ((o_kind == AOCD_KIND_REGRM && o_mem) ? 8'h0F : 8'h03))
      else $error("step count wrong");
   chk_sign_change: assert property (
      o_op_valid && o_op == AOCD_OP_NEG |-> o_clk_wide_min == (o_mem ? 8'h0A : 8'h03))
      else $error("sign change count wrong");

endmodule : aocd_decoder

// file: sim/tb.sv
`timescale 1ns/10ps
module tb
   import aocd_pkg::*;
();
   logic i_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic i_byte_valid = 1'b0;
   logic [7:0] i_byte = 8'h00;
   logic o_byte_ready, o_op_valid, o_size_bit, o_orient_bit, o_mem;
   aocd_op_t o_op;
   aocd_kind_t o_kind;
   logic o_widen_bit;
   logic [1:0] o_addr_kind_field;
   logic [2:0] o_operand_select_field, o_mem_operand_field;
   logic [1:0] o_seg_field, o_disp_count, o_imm_count;
   logic [7:0] o_clk_wide_min, o_clk_wide_max, o_clk_narrow_min, o_clk_narrow_max;
   int n_mismatch = 0;
   int tests_run = 0;
   int cycles = 0;
   always #2 i_clk = ~i_clk;
   aocd_decoder dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_byte_valid(i_byte_valid),
      .i_byte(i_byte), .o_byte_ready(o_byte_ready), .o_op_valid(o_op_valid), .o_op(o_op),
      .o_kind(o_kind), .o_seg_field(o_seg_field), .o_size_bit(o_size_bit),
      .o_orient_bit(o_orient_bit), .o_widen_bit(o_widen_bit), .o_mem(o_mem),
      .o_addr_kind_field(o_addr_kind_field), .o_operand_select_field(o_operand_select_field),
      .o_mem_operand_field(o_mem_operand_field), .o_disp_count(o_disp_count),
      .o_imm_count(o_imm_count), .o_clk_wide_min(o_clk_wide_min),
      .o_clk_wide_max(o_clk_wide_max), .o_clk_narrow_min(o_clk_narrow_min),
      .o_clk_narrow_max(o_clk_narrow_max));
   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run
   // Whole run is about 150 cycles; generous ceiling
   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         n_mismatch++;
         complete_run();
      end
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %0h, seen %0h", nm, exp, got);
      end
   endtask : chk
   // Bytes back to back; result pulse stands only in the cycle after the last take
   task automatic go(input logic [7:0] b[$], input aocd_op_t op, input logic [1:0] imm,
      input logic [31:0] clks);
      foreach (b[i])
      begin
         i_byte_valid = 1'b1;
         i_byte = b[i];
         @(negedge i_clk);
      end
      i_byte_valid = 1'b0;
      chk("op_valid", 1, o_op_valid);
      chk("op", op, o_op);
      chk("imm_count", imm, o_imm_count);
      chk("clocks", clks, {o_clk_wide_min, o_clk_wide_max, o_clk_narrow_min, o_clk_narrow_max});
      @(negedge i_clk);
      chk("op_valid_end", 0, o_op_valid);
   endtask : go
   task automatic t_prefix();
      logic [7:0] pf [4] = '{PFX_EXTRA, PFX_CODE, PFX_STACK, PFX_DATA};
      for (int i = 0; i < 4; i++)
      begin
         go('{pf[i]}, AOCD_OP_SEG, 0, 32'h02020202);
         chk("seg", i, o_seg_field);
      end
      $display("test prefix done");
   endtask : t_prefix
   task automatic t_regrm();
      go('{8'h01, 8'h06, 8'h00, 8'h10}, AOCD_OP_SUM, 0, 32'h0A0A0E0E);
      chk("mem", 1, o_mem);
      chk("disp", 2, o_disp_count);
      chk("kind", AOCD_KIND_REGRM, o_kind);
      chk("fields", 8'h06, {o_addr_kind_field, o_operand_select_field, o_mem_operand_field});
      go('{8'h02, 8'hC0}, AOCD_OP_SUM, 0, 32'h03030303);
      chk("dir_size", 2'b10, {o_orient_bit, o_size_bit});
      go('{8'h12, 8'h45, 8'h07}, AOCD_OP_SUMC, 0, 32'h0A0A0A0A);
      go('{8'h29, 8'hC1}, AOCD_OP_DIFF, 0, 32'h03030303);
      go('{8'h1B, 8'h47, 8'h01}, AOCD_OP_BDIFF, 0, 32'h0A0A0E0E);
      go('{8'h3B, 8'hC3}, AOCD_OP_CMP, 0, 32'h03030303);
      go('{8'h38, 8'h4F, 8'h02}, AOCD_OP_CMP, 0, 32'h0A0A0A0A);
      $display("test register forms done");
   endtask : t_regrm
   task automatic t_imm();
      go('{8'h81, 8'hC0, 8'h34, 8'h12}, AOCD_OP_SUM, 2, 32'h04040404);
      go('{8'h83, 8'hD0, 8'h05}, AOCD_OP_SUMC, 1, 32'h04040404);
      chk("kind", AOCD_KIND_IMMRM, o_kind);
      chk("widen", 1, o_widen_bit);
      chk("select", 3'h2, o_operand_select_field);
      go('{8'h80, 8'h1E, 8'h00, 8'h10, 8'h05}, AOCD_OP_BDIFF, 1, 32'h10101010);
      go('{8'h81, 8'h6E, 8'h05, 8'h34, 8'h12}, AOCD_OP_DIFF, 2, 32'h10101414);
      go('{8'h82, 8'hF8, 8'h05}, AOCD_OP_CMP, 1, 32'h03030303);
      go('{8'h83, 8'h3E, 8'h00, 8'h10, 8'h05}, AOCD_OP_CMP, 1, 32'h0A0A0E0E);
      $display("test immediate group done");
   endtask : t_imm
   task automatic t_acc();
      go('{8'h04, 8'h12}, AOCD_OP_SUM, 1, 32'h03030303);
      chk("kind", AOCD_KIND_ACC, o_kind);
      go('{8'h05, 8'h34, 8'h12}, AOCD_OP_SUM, 2, 32'h04040404);
      go('{8'h14, 8'h12}, AOCD_OP_SUMC, 1, 32'h03030303);
      go('{8'h2D, 8'h34, 8'h12}, AOCD_OP_DIFF, 2, 32'h04040404);
      go('{8'h1C, 8'h12}, AOCD_OP_BDIFF, 1, 32'h03030303);
      go('{8'h3D, 8'h34, 8'h12}, AOCD_OP_CMP, 2, 32'h04040404);
      $display("test accumulator done");
   endtask : t_acc
   task automatic t_unary();
      go('{8'hF6, 8'hD8}, AOCD_OP_NEG, 0, 32'h03030303);
      go('{8'hF7, 8'h1E, 8'h00, 8'h10}, AOCD_OP_NEG, 0, 32'h0A0A0E0E);
      go('{8'hF6, 8'hE0}, AOCD_OP_MUL, 0, 32'h1A1C1A1C);
      go('{8'hF7, 8'hE0}, AOCD_OP_MUL, 0, 32'h23252325);
      go('{8'hF6, 8'h26, 8'h00, 8'h10}, AOCD_OP_MUL, 0, 32'h20222022);
      go('{8'hF7, 8'h26, 8'h00, 8'h10}, AOCD_OP_MUL, 0, 32'h292B2930);
      go('{8'hF6, 8'hC0}, AOCD_OP_ILLEGAL, 0, 32'h00000000);
      $display("test unary done");
   endtask : t_unary
   task automatic t_step();
      go('{8'hFE, 8'hC0}, AOCD_OP_INC, 0, 32'h03030303);
      go('{8'hFF, 8'h0E, 8'h00, 8'h10}, AOCD_OP_DEC, 0, 32'h0F0F1313);
      go('{8'h40}, AOCD_OP_INC, 0, 32'h03030303);
      go('{8'h49}, AOCD_OP_DEC, 0, 32'h03030303);
      $display("test step done");
   endtask : t_step
   task automatic t_single();
      go('{8'h37}, AOCD_OP_ASF, 0, 32'h08080808);
      go('{8'h3F}, AOCD_OP_ADF, 0, 32'h07070707);
      go('{8'h27}, AOCD_OP_BSF, 0, 32'h04040404);
      go('{8'h2F}, AOCD_OP_BDF, 0, 32'h04040404);
      go('{8'h90}, AOCD_OP_ILLEGAL, 0, 32'h00000000);
      $display("test adjust done");
   endtask : t_single
   initial
   begin
      repeat (16) @(negedge i_clk);
      i_rst_b = 1'b1;
      @(negedge i_clk);
      chk("ready", 1, o_byte_ready);
      t_prefix();
      t_regrm();
      t_imm();
      t_acc();
      t_unary();
      t_step();
      t_single();
      complete_run();
   end
endmodule : tb
